// *** boot_strap_latch.sv ***
// Functional notes
// - Sample five straps at every system reset release; hold until the next release.
// - Latched strap bits are readable by software in the strap value register.
// - Weak pulls attach to strap pins while reset is active, giving defaults.
// - After release and latching, strap pins return to ordinary functional use.
// - Strap A 1 boots flash; A 0 with B 0 enters download boot.
// - Jtag data-out strap 1 enables boot log on UART; 0 keeps silent.
// - Firmware override bits replace strapped SDIO voltage and timing after boot.
`timescale 1ns/10ps
module boot_strap_latch (
   input wire logic i_clk, // 10 MHz clock
   input wire logic i_srst, // Power-on reset, clears all state but the synchronizers; weak pulls come up enabled
   input wire logic i_sys_rst, // System reset request, asynchronous, high while active
   input wire logic [boot_strap_pkg::STRAP_COUNT-1:0] i_strap_pin, // Strap pin levels
   input wire logic [boot_strap_pkg::ADDR_WIDTH-1:0] i_addr, // Register address
   input wire logic [boot_strap_pkg::DATA_WIDTH-1:0] i_wdata, // Register write data
   input wire logic i_wr, // Write strobe
   input wire logic i_rd, // Read strobe
   output logic [boot_strap_pkg::DATA_WIDTH-1:0] o_rdata, // Read data, cycle after i_rd
   output logic [boot_strap_pkg::STRAP_COUNT-1:0] o_pull_up_en, // Weak pull-up enables
   output logic [boot_strap_pkg::STRAP_COUNT-1:0] o_pull_down_en, // Weak pull-down enables
   output logic o_pins_functional, // Strap pins handed to normal use
   output logic o_straps_latched, // Strap bits valid
   output logic o_boot_from_flash, // Boot from SPI flash
   output logic o_download_boot, // Enter download boot
   output logic o_boot_log_en, // Boot log on first_uart_transmit_line
   output logic o_sdio_rail_1v8, // SDIO rail at 1.8 V, else 3.3 V
   output logic o_sdio_sample_rise, // SDIO slave samples on rising edge
   output logic o_sdio_output_rise // SDIO slave drives on rising edge
);
   import boot_strap_pkg::*;

   logic [STRAP_COUNT-1:0] pin_meta_reg;
   logic [STRAP_COUNT-1:0] pin_sync_reg;
   logic rst_meta_reg;
   logic rst_sync_reg;
   latch_state_type state_reg;
   latch_state_type state_next;
   logic [STRAP_COUNT-1:0] strap_reg;
   logic [STRAP_COUNT-1:0] strap_next;
   logic latched_reg;
   logic [OVR_WIDTH-1:0] ovr_reg;
   logic [OVR_WIDTH-1:0] ovr_next;
   logic [DATA_WIDTH-1:0] rdata_next;
   logic [STS_WIDTH-1:0] status_word;

   wire capture = (state_reg == ST_IN_RESET) && !rst_sync_reg;
   wire in_reset = (state_next == ST_IN_RESET);
   wire ovr_write = i_wr && (i_addr == OFS_SDIO_OVERRIDE);

   wire strap_data_in = strap_reg[BIT_JTAG_DATA_IN];
   wire strap_a = strap_reg[BIT_BOOT_SEL_A];
   wire strap_b = strap_reg[BIT_BOOT_SEL_B];
   wire strap_data_out = strap_reg[BIT_JTAG_DATA_OUT];
   wire strap_edge = strap_reg[BIT_SDIO_EDGE];

   wire flash_next = latched_reg && strap_a;
   wire download_next = latched_reg && !strap_a && !strap_b;
   wire log_next = latched_reg && strap_data_out;
   wire rail_next = ovr_reg[OVR_VOLT_EN] ? ovr_reg[OVR_VOLT_1V8] : strap_data_in;
   wire sample_next = ovr_reg[OVR_TIMING_EN] ? ovr_reg[OVR_SAMPLE_RISE] : strap_data_out;
   wire output_next = ovr_reg[OVR_TIMING_EN] ? ovr_reg[OVR_OUTPUT_RISE] : strap_edge;

   // Pin and reset inputs come from outside the clock domain.
   always_ff @(posedge i_clk) begin
      pin_meta_reg <= i_strap_pin;
      pin_sync_reg <= pin_meta_reg;
      rst_meta_reg <= i_sys_rst;
      rst_sync_reg <= rst_meta_reg;
   end

   // A system reset sends the block back to sampling; release latches once.
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IN_RESET: begin
            if (!rst_sync_reg) begin
               state_next = ST_RUNNING;
            end
         end
         ST_RUNNING: begin
            if (rst_sync_reg) begin
               state_next = ST_IN_RESET;
            end
         end
         default: begin
            state_next = ST_IN_RESET;
         end
      endcase
   end

   // Strap bits change only at release; bus writes never reach them.
   assign strap_next = capture ? pin_sync_reg : strap_reg;
   assign ovr_next = ovr_write ? i_wdata[OVR_WIDTH-1:0] : ovr_reg;

   // Status fields are placed by their named positions so the map cannot drift.
   assign status_word[STS_FLASH_BOOT] = o_boot_from_flash;
   assign status_word[STS_DOWNLOAD_BOOT] = o_download_boot;
   assign status_word[STS_RAIL_1V8] = o_sdio_rail_1v8;
   assign status_word[STS_LOG_EN] = o_boot_log_en;
   assign status_word[STS_SAMPLE_RISE] = o_sdio_sample_rise;
   assign status_word[STS_OUTPUT_RISE] = o_sdio_output_rise;
   assign status_word[STS_LATCHED] = latched_reg;

   // Unmapped addresses read as zero.
   assign rdata_next = !i_rd ? RDATA_ZERO :
      (i_addr == OFS_STRAP_VALUE) ? {{(DATA_WIDTH-STRAP_COUNT){1'b0}}, strap_reg} :
      (i_addr == OFS_SDIO_OVERRIDE) ? {{(DATA_WIDTH-OVR_WIDTH){1'b0}}, ovr_reg} :
      (i_addr == OFS_BOOT_STATUS) ? {{(DATA_WIDTH-STS_WIDTH){1'b0}}, status_word} :
      RDATA_ZERO;

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         state_reg <= ST_IN_RESET;
         strap_reg <= STRAP_RESET;
         latched_reg <= 1'b0;
         ovr_reg <= OVR_RESET;
         o_rdata <= RDATA_ZERO;
      end else begin
         state_reg <= state_next;
         strap_reg <= strap_next;
         latched_reg <= latched_reg || capture;
         ovr_reg <= ovr_next;
         o_rdata <= rdata_next;
      end
   end

   // Pin control follows the state: pulls in reset, normal function after.
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_pull_up_en <= PULL_UP_MASK;
         o_pull_down_en <= PULL_DOWN_MASK;
         o_pins_functional <= 1'b0;
      end else begin
         o_pull_up_en <= in_reset ? PULL_UP_MASK : STRAP_RESET;
         o_pull_down_en <= in_reset ? PULL_DOWN_MASK : STRAP_RESET;
         o_pins_functional <= !in_reset;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_straps_latched <= 1'b0;
         o_boot_from_flash <= 1'b0;
         o_download_boot <= 1'b0;
         o_boot_log_en <= 1'b0;
         o_sdio_rail_1v8 <= 1'b0;
         o_sdio_sample_rise <= 1'b0;
         o_sdio_output_rise <= 1'b0;
      end else begin
         o_straps_latched <= latched_reg;
         o_boot_from_flash <= flash_next;
         o_download_boot <= download_next;
         o_boot_log_en <= log_next;
         o_sdio_rail_1v8 <= rail_next;
         o_sdio_sample_rise <= sample_next;
         o_sdio_output_rise <= output_next;
      end
   end

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_srst);

   a_strap_held_steady: assert property (
      (state_reg == ST_RUNNING) && $past(state_reg == ST_RUNNING) |-> $stable(strap_reg))
      else $error("Strap bits changed outside a reset release.");

   a_strap_capture_value: assert property (
      capture |=> strap_reg == $past(pin_sync_reg) && latched_reg)
      else $error("Strap bits did not take the pin levels at release.");

   a_strap_readback: assert property (
      i_rd && i_addr == OFS_STRAP_VALUE && !capture |=> o_rdata[STRAP_COUNT-1:0] == strap_reg
         && o_rdata[DATA_WIDTH-1:STRAP_COUNT] == '0)
      else $error("Strap value register read returned wrong data.");

   a_pulls_in_reset: assert property (
      rst_sync_reg ##1 rst_sync_reg |=> o_pull_up_en == PULL_UP_MASK
         && o_pull_down_en == PULL_DOWN_MASK && !o_pins_functional)
      else $error("Weak pulls not applied during reset.");

   a_pins_released: assert property (
      capture |=> o_pins_functional && o_pull_up_en == STRAP_RESET && o_pull_down_en == STRAP_RESET)
      else $error("Strap pins not returned to normal use after latching.");

   a_rail_select: assert property (
      !ovr_reg[OVR_VOLT_EN] && $stable(ovr_reg) && $stable(strap_reg)
         |=> o_sdio_rail_1v8 == $past(strap_data_in))
      else $error("SDIO rail level does not follow the data-in strap.");

   a_boot_mode: assert property (
      latched_reg && $stable(strap_reg) |=> o_boot_from_flash == $past(strap_a)
         && o_download_boot == ($past(!strap_a) && $past(!strap_b)))
      else $error("Boot mode does not match the boot select straps.");

   a_log_enable: assert property (
      latched_reg && $stable(strap_reg) |=> o_boot_log_en == $past(strap_data_out))
      else $error("Boot log enable does not follow the data-out strap.");

   a_sdio_timing: assert property (
      !ovr_reg[OVR_TIMING_EN] && $stable(ovr_reg) && $stable(strap_reg)
         |=> o_sdio_sample_rise == $past(strap_data_out) && o_sdio_output_rise == $past(strap_edge))
      else $error("SDIO timing does not follow the straps.");

   a_override_applies: assert property (
      ovr_write && i_wdata[OVR_VOLT_EN] && i_wdata[OVR_TIMING_EN] ##1 !ovr_write
         |=> o_sdio_rail_1v8 == $past(i_wdata[OVR_VOLT_1V8], 2)
         && o_sdio_sample_rise == $past(i_wdata[OVR_SAMPLE_RISE], 2)
         && o_sdio_output_rise == $past(i_wdata[OVR_OUTPUT_RISE], 2))
      else $error("Firmware override did not take effect.");

   a_write_no_effect: assert property (
      i_wr && i_addr == OFS_STRAP_VALUE && !capture |=> $stable(strap_reg))
      else $error("Write changed the latched strap bits.");

   // Read path: idle cycles, override and status words, unmapped offsets.
   a_rdata_idle_zero: assert property (
      !i_rd |=> o_rdata == RDATA_ZERO)
      else $error("Read data not zero outside a read answer.");

   a_override_readback: assert property (
      i_rd && i_addr == OFS_SDIO_OVERRIDE |=> o_rdata[OVR_WIDTH-1:0] == $past(ovr_reg)
         && o_rdata[DATA_WIDTH-1:OVR_WIDTH] == '0)
      else $error("Override register read returned wrong data.");

   a_status_readback: assert property (
      i_rd && i_addr == OFS_BOOT_STATUS
         |=> o_rdata[STS_FLASH_BOOT] == $past(o_boot_from_flash)
         && o_rdata[STS_DOWNLOAD_BOOT] == $past(o_download_boot)
         && o_rdata[STS_RAIL_1V8] == $past(o_sdio_rail_1v8)
         && o_rdata[STS_LOG_EN] == $past(o_boot_log_en)
         && o_rdata[STS_LATCHED] == $past(latched_reg))
      else $error("Boot status read returned wrong fields.");

   a_unmapped_zero: assert property (
      i_rd && i_addr != OFS_STRAP_VALUE && i_addr != OFS_SDIO_OVERRIDE
         && i_addr != OFS_BOOT_STATUS |=> o_rdata == RDATA_ZERO)
      else $error("Unmapped read did not return zero.");

   // Latch, pull and pin hand-over checks.
   a_latched_sticky: assert property (
      latched_reg |=> latched_reg)
      else $error("Latched flag dropped before power-down.");

   a_latched_output: assert property (
      1'b1 |=> o_straps_latched == $past(latched_reg))
      else $error("Latched output does not follow the latch flag.");

   a_strap_kept_in_reset: assert property (
      state_reg == ST_IN_RESET && rst_sync_reg |=> $stable(strap_reg))
      else $error("Strap bits changed while system reset was active.");

   a_reset_reentry: assert property (
      state_reg == ST_RUNNING && rst_sync_reg |=> state_reg == ST_IN_RESET
         && !o_pins_functional)
      else $error("System reset did not return the pins to sampling.");

   a_pulls_exclusive: assert property (
      (o_pull_up_en & o_pull_down_en) == STRAP_RESET)
      else $error("A strap pin has both weak pulls enabled.");

   a_pulls_match_state: assert property (
      !o_pins_functional |-> o_pull_up_en == PULL_UP_MASK
         && o_pull_down_en == PULL_DOWN_MASK)
      else $error("Weak pulls do not match the reset state.");

   a_functional_state: assert property (
      o_pins_functional == (state_reg == ST_RUNNING))
      else $error("Pin hand-over does not match the latch state.");

   a_functional_no_pulls: assert property (
      o_pins_functional |-> o_pull_up_en == STRAP_RESET && o_pull_down_en == STRAP_RESET)
      else $error("Weak pulls left on after pin hand-over.");

   // Boot decode and firmware override checks.
   a_boot_gated: assert property (
      !latched_reg |=> !o_boot_from_flash && !o_download_boot && !o_boot_log_en)
      else $error("Boot outputs active before the straps were latched.");

   a_boot_exclusive: assert property (
      !(o_boot_from_flash && o_download_boot))
      else $error("Flash boot and download boot selected together.");

   a_rail_override: assert property (
      ovr_reg[OVR_VOLT_EN] |=> o_sdio_rail_1v8 == $past(ovr_reg[OVR_VOLT_1V8]))
      else $error("Rail override bit not applied.");

   a_timing_override: assert property (
      ovr_reg[OVR_TIMING_EN] |=> o_sdio_sample_rise == $past(ovr_reg[OVR_SAMPLE_RISE])
         && o_sdio_output_rise == $past(ovr_reg[OVR_OUTPUT_RISE]))
      else $error("Timing override bits not applied.");

   a_override_write: assert property (
      ovr_write |=> ovr_reg == $past(i_wdata[OVR_WIDTH-1:0]))
      else $error("Override register did not take the written value.");

   a_override_hold: assert property (
      !ovr_write |=> $stable(ovr_reg))
      else $error("Override register changed without a write.");

endmodule

// *** boot_strap_pkg.sv ***
package boot_strap_pkg;

   localparam int STRAP_COUNT = 5;
   localparam int ADDR_WIDTH = 4;
   localparam int DATA_WIDTH = 32;

   // Bit positions of the five straps in every strap-wide vector.
   localparam int BIT_JTAG_DATA_IN = 0;
   localparam int BIT_BOOT_SEL_A = 1;
   localparam int BIT_BOOT_SEL_B = 2;
   localparam int BIT_JTAG_DATA_OUT = 3;
   localparam int BIT_SDIO_EDGE = 4;

   // Weak pulls applied while reset is active; they set the default levels.
   localparam logic [4:0] PULL_UP_MASK = 5'h1A;
   localparam logic [4:0] PULL_DOWN_MASK = 5'h05;
   localparam logic [4:0] STRAP_RESET = 5'h00;

   // Register offsets (byte addresses).
   localparam logic [3:0] OFS_STRAP_VALUE = 4'h0;
   localparam logic [3:0] OFS_SDIO_OVERRIDE = 4'h4;
   localparam logic [3:0] OFS_BOOT_STATUS = 4'h8;

   // Override register fields.
   localparam int OVR_VOLT_EN = 0;
   localparam int OVR_VOLT_1V8 = 1;
   localparam int OVR_TIMING_EN = 2;
   localparam int OVR_SAMPLE_RISE = 3;
   localparam int OVR_OUTPUT_RISE = 4;
   localparam int OVR_WIDTH = 5;
   localparam logic [4:0] OVR_RESET = 5'h00;

   // Status register fields.
   localparam int STS_FLASH_BOOT = 0;
   localparam int STS_DOWNLOAD_BOOT = 1;
   localparam int STS_RAIL_1V8 = 2;
   localparam int STS_LOG_EN = 3;
   localparam int STS_SAMPLE_RISE = 4;
   localparam int STS_OUTPUT_RISE = 5;
   localparam int STS_LATCHED = 6;
   localparam int STS_WIDTH = 7;

   localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

   typedef enum logic [1:0] {
      ST_IN_RESET,
      ST_RUNNING
   } latch_state_type;

endpackage

// *** strap_board_model.sv ***
`timescale 1ns/10ps
module strap_board_model #(
   parameter bit FLASH_1V8 = 1'b0
) (
   input wire logic i_clk, // Board clock for the float pattern
   input wire logic [4:0] i_host_drive, // Host GPIO drive enables
   input wire logic [4:0] i_host_level, // Host GPIO levels
   input wire logic [4:0] i_pull_up_en, // Device weak pull-ups
   input wire logic [4:0] i_pull_down_en, // Device weak pull-downs
   output logic [4:0] o_pin // Resolved strap pin levels
);
   logic [4:0] float_reg = 5'h15;
   logic [4:0] level;
   // An undriven, unpulled pin wanders so a stale level is never read.
   always_ff @(posedge i_clk) begin
      float_reg <= ~float_reg;
   end
   // A 3.3 V flash board never presents a high data-in strap.
   assign level = FLASH_1V8 ? i_host_level : (i_host_level & 5'h1E);
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         if (i_host_drive[i]) begin
            o_pin[i] = level[i];
         end else if (i_pull_up_en[i]) begin
            o_pin[i] = 1'b1;
         end else if (i_pull_down_en[i]) begin
            o_pin[i] = 1'b0;
         end else begin
            o_pin[i] = float_reg[i];
         end
      end
   end
endmodule

// *** boot_strap_latch_tb_top.sv ***
`timescale 1ns/10ps
module boot_strap_latch_tb_top;
   import boot_strap_pkg::*;
   logic i_clk = 1'b0;
   logic i_srst = 1'b1;
   logic i_sys_rst = 1'b1;
   logic [3:0] i_addr = 4'h0;
   logic [31:0] i_wdata = 32'h0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [4:0] host_drive = 5'h00;
   logic [4:0] host_level = 5'h00;
   logic [4:0] strap_pin, pu_en, pd_en;
   logic [31:0] o_rdata;
   logic funct, latched, flash, dl, log_en, rail, smp, outr;
   logic [5:0] cfg_seen;
   logic [4:0] pats [6] = '{5'h00, 5'h11, 5'h0A, 5'h0C, 5'h17, 5'h1F};
   int err_total = 0;
   int checked = 0;
   assign cfg_seen = {outr, smp, log_en, rail, dl, flash};
   always #50 i_clk = ~i_clk;
   strap_board_model #(.FLASH_1V8(1'b1)) strap_board_model_inst (.i_clk(i_clk),
      .i_host_drive(host_drive), .i_host_level(host_level), .i_pull_up_en(pu_en),
      .i_pull_down_en(pd_en), .o_pin(strap_pin));
   boot_strap_latch boot_strap_latch_inst (.i_clk(i_clk), .i_srst(i_srst),
      .i_sys_rst(i_sys_rst), .i_strap_pin(strap_pin), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_pull_up_en(pu_en),
      .o_pull_down_en(pd_en), .o_pins_functional(funct), .o_straps_latched(latched),
      .o_boot_from_flash(flash), .o_download_boot(dl), .o_boot_log_en(log_en),
      .o_sdio_rail_1v8(rail), .o_sdio_sample_rise(smp), .o_sdio_output_rise(outr));
   task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask
   // Config bits in status order: flash, download, rail, log, sample, output.
   function automatic logic [5:0] cfg_of(input logic [4:0] s);
      return {s[4], s[3], s[3], s[0], ~s[1] & ~s[2], s[1]};
   endfunction
   task automatic latch_run(input logic [4:0] lvl, input logic [4:0] drv);
      logic [4:0] s;
      logic [31:0] d;
      s = (drv & lvl) | (~drv & PULL_UP_MASK);
      @(posedge i_clk);
      host_drive <= drv;
      host_level <= lvl;
      i_sys_rst <= 1'b1;
      repeat (4) @(posedge i_clk);
      #1 chk_word("pull_up_en", {27'h0, PULL_UP_MASK}, {27'h0, pu_en});
      chk_word("pull_down_en", {27'h0, PULL_DOWN_MASK}, {27'h0, pd_en});
      chk_word("pins_functional", 32'h0, {31'h0, funct});
      @(posedge i_clk);
      i_sys_rst <= 1'b0;
      repeat (6) @(posedge i_clk);
      host_drive <= 5'h00;
      #1 chk_word("released pulls", 32'h0, {22'h0, pu_en, pd_en});
      chk_word("pins_functional", 32'h1, {31'h0, funct});
      chk_word("straps_latched", 32'h1, {31'h0, latched});
      chk_word("config outputs", {26'h0, cfg_of(s)}, {26'h0, cfg_seen});
      bus_rd(OFS_STRAP_VALUE, d);
      chk_word("strap value", {27'h0, s}, d);
      bus_rd(OFS_BOOT_STATUS, d);
      chk_word("boot status", {25'h0, 1'b1, cfg_of(s)}, d);
      repeat (3) @(posedge i_clk);
      bus_rd(OFS_STRAP_VALUE, d);
      chk_word("strap held", {27'h0, s}, d);
      $display("latch test done, straps %h", s);
   endtask
   task automatic reg_run();
      logic [31:0] d;
      bus_wr(OFS_STRAP_VALUE, 32'hFFFF_FFFF);
      bus_wr(OFS_BOOT_STATUS, 32'h0000_0000);
      bus_rd(OFS_STRAP_VALUE, d);
      chk_word("strap after write", 32'h0000_001F, d);
      bus_rd(4'hC, d);
      chk_word("unmapped read", 32'h0, d);
      bus_wr(OFS_SDIO_OVERRIDE, 32'h0000_0005);
      bus_rd(OFS_SDIO_OVERRIDE, d);
      chk_word("override readback", 32'h0000_0005, d);
      #1 chk_word("overridden config", 32'h09, {26'h0, cfg_seen});
      bus_wr(OFS_SDIO_OVERRIDE, 32'h0000_0000);
      repeat (2) @(posedge i_clk);
      #1 chk_word("strapped config", 32'h3D, {26'h0, cfg_seen});
      $display("register test done");
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge i_clk);
      i_srst <= 1'b0;
      latch_run(5'h00, 5'h00);
      for (int i = 0; i < 6; i++) begin
         latch_run(pats[i], 5'h1F);
      end
      reg_run();
      close_out();
   end
   initial begin
      #(3000 * 100);
      err_total++;
      close_out();
   end
endmodule
